// [atc_cfg.svh]
// Register offsets, field widths and reset values of the coefficient trim bank
`ifndef ATC_CFG_SVH
`define ATC_CFG_SVH

`define ATC_DATA_W       8
`define ATC_ADDR_W       8
`define ATC_IDX_W        4
`define ATC_NUM_REGS     9

`define ATC_OFF_OC11     8'h69
`define ATC_OFF_OC12     8'h6a
`define ATC_OFF_OC13     8'h6b
`define ATC_OFF_OC14     8'h6c
`define ATC_OFF_GC1      8'h6d
`define ATC_OFF_GC2      8'h6e
`define ATC_OFF_GC3      8'h6f
`define ATC_OFF_GC4      8'h70
`define ATC_OFF_GC5      8'h71
`define ATC_OFF_FIRST    `ATC_OFF_OC11
`define ATC_OFF_LAST     `ATC_OFF_GC5

`define ATC_W_OFF1       12
`define ATC_W_OFF2       12
`define ATC_W_GAIN0      15
`define ATC_W_GAIN1      14
`define ATC_W_GAIN2      11

`define ATC_RST_BYTE     8'h00
`define ATC_SPARE_VAL    6'h00
`define ATC_OC11_LOW     2'h0

`endif

// [atc_pkg.sv]
// Types shared by the coefficient trim bank modules
`include "atc_cfg.svh"
package atc_pkg;
   typedef struct packed
   {
      logic [`ATC_W_OFF1-1:0]  offset_coeff_order1;
      logic [`ATC_W_OFF2-1:0]  offset_coeff_order2;
      logic [`ATC_W_GAIN0-1:0] gain_coeff_order0;
      logic [`ATC_W_GAIN1-1:0] gain_coeff_order1;
      logic [`ATC_W_GAIN2-1:0] gain_coeff_order2;
   } atc_coeff_t;

   typedef struct packed
   {
      logic [`ATC_ADDR_W-1:0] addr;
      logic [`ATC_DATA_W-1:0] wdata;
      logic                   wr;
      logic                   rd;
   } atc_bus_req_t;

   typedef logic [`ATC_NUM_REGS-1:0][`ATC_DATA_W-1:0] atc_bank_t;

   typedef struct packed
   {
      atc_coeff_t             coeff;
      logic [`ATC_DATA_W-1:0] rdata;
      logic                   rvalid;
      logic                   wr_ignored;
   } atc_state_t;
endpackage

// [atc_decode.sv]
// Address decode of the coefficient trim bank window
`timescale 1ns/10ps
`include "atc_cfg.svh"
module atc_decode
   import atc_pkg::*;
(
   input  wire logic [`ATC_ADDR_W-1:0] addr,
   output logic                        hit,
   output logic [`ATC_IDX_W-1:0]       idx
);
   logic [`ATC_ADDR_W-1:0] diff;

   always_comb
   begin
      diff = addr - `ATC_OFF_FIRST;
      hit  = (addr >= `ATC_OFF_FIRST) && (addr <= `ATC_OFF_LAST);
      // Index forced to zero off the window so no out-of-range select is made
      idx  = hit ? diff[`ATC_IDX_W-1:0] : '0;
   end
endmodule

// [atc_pack.sv]
// Splits the stored coefficients into the readable byte registers
`timescale 1ns/10ps
`include "atc_cfg.svh"
module atc_pack
   import atc_pkg::*;
(
   input  wire atc_coeff_t coeff,
   output atc_bank_t       bank
);
   always_comb
   begin
      // Low two bits belong to another coefficient kept outside this bank
      bank[0] = {coeff.offset_coeff_order1[5:0], `ATC_OC11_LOW};
      bank[1] = {coeff.offset_coeff_order2[1:0],
                 coeff.offset_coeff_order1[11:6]};
      bank[2] = coeff.offset_coeff_order2[9:2];
      bank[3] = {`ATC_SPARE_VAL,
                 coeff.offset_coeff_order2[11:10]};
      bank[4] = coeff.gain_coeff_order0[7:0];
      bank[5] = {coeff.gain_coeff_order1[0],
                 coeff.gain_coeff_order0[14:8]};
      bank[6] = coeff.gain_coeff_order1[8:1];
      bank[7] = {coeff.gain_coeff_order2[2:0],
                 coeff.gain_coeff_order1[13:9]};
      bank[8] = coeff.gain_coeff_order2[10:3];
   end
endmodule

// [atc_trim_bank.sv]
// Read-only temperature coefficient trim bank with register port
// What this block does
// - Offset order1 bits 11-6 at 0x6A[5:0]
// - Offset order2 bits 1-0 at 0x6A[7:6]
// - Offset order2 bits 9-2 fill 0x6B
// - Offset order2 bits 11-10 at 0x6C[1:0]
// - 0x6C bits 7-2 spare, read zero
// - Gain order0 bits 7-0 fill 0x6D
// - Gain order0 bits 14-8 at 0x6E[6:0]
// - Gain order1 bit 0 at 0x6E[7]
// - Gain order1 bits 8-1 fill 0x6F
// - 0x70: gain1 bits 13-9, gain2 bits 2-0
// - Gain order2 bits 10-3 fill 0x71
// - All coefficient bits read-only, reset zero
// - Offset order1 bits 5-0 in 0x69
`timescale 1ns/10ps
`include "atc_cfg.svh"
module atc_trim_bank
   import atc_pkg::*;
(
   input  wire logic                   ref_clk,
   input  wire logic                   reset,
   input  wire atc_bus_req_t           bus_req,
   output logic [`ATC_DATA_W-1:0]      bus_rdata,
   output logic                        bus_rvalid,
   output logic                        wr_ignored,
   input  wire logic                   trim_load,
   input  wire atc_coeff_t             trim_coeff,
   output atc_coeff_t                  coeff_out
);
   atc_state_t st_q;
   atc_state_t st_d;
   atc_bank_t  bank;
   logic       hit;
   logic [`ATC_IDX_W-1:0] idx;

   atc_decode u_decode
   (
      .addr (bus_req.addr),
      .hit  (hit),
      .idx  (idx)
   );

   atc_pack u_pack
   (
      .coeff (st_q.coeff),
      .bank  (bank)
   );

   always_comb
   begin
      st_d            = st_q;
      st_d.rvalid     = 1'b0;
      st_d.rdata      = `ATC_RST_BYTE;
      // Writes to the window are only flagged; the data path has no write port at all
      st_d.wr_ignored = bus_req.wr && hit;
      // Trim values come only from the on-chip loader, never from software
      if (trim_load)
      begin
         st_d.coeff = trim_coeff;
      end
      if (bus_req.rd)
      begin
         st_d.rvalid = 1'b1;
         // Unmapped reads answer zero rather than stall the master
         st_d.rdata  = hit ? bank[idx] : `ATC_RST_BYTE;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign bus_rdata  = st_q.rdata;
   assign bus_rvalid = st_q.rvalid;
   assign wr_ignored = st_q.wr_ignored;
   assign coeff_out  = st_q.coeff;

   default clocking cb @(posedge ref_clk);
   endclocking

   default disable iff (reset);

   sequence s_rd(logic [`ATC_ADDR_W-1:0] a);
      bus_req.rd && (bus_req.addr == a);
   endsequence

   property p_rd_oc12_low;
      s_rd(`ATC_OFF_OC12)
      |=> bus_rvalid
          && (bus_rdata[5:0] == $past(st_q.coeff.offset_coeff_order1[11:6]));
   endproperty
   a_rd_oc12_low: assert property (p_rd_oc12_low)
      else $error("0x6a low field does not match offset order1");

   property p_rd_oc12_high;
      s_rd(`ATC_OFF_OC12)
      |=> bus_rdata[7:6] == $past(st_q.coeff.offset_coeff_order2[1:0]);
   endproperty
   a_rd_oc12_high: assert property (p_rd_oc12_high)
      else $error("0x6a high field does not match offset order2");

   property p_rd_oc13;
      s_rd(`ATC_OFF_OC13)
      |=> bus_rdata == $past(st_q.coeff.offset_coeff_order2[9:2]);
   endproperty
   a_rd_oc13: assert property (p_rd_oc13)
      else $error("0x6b does not match offset order2");

   property p_rd_oc14_low;
      s_rd(`ATC_OFF_OC14)
      |=> bus_rdata[1:0] == $past(st_q.coeff.offset_coeff_order2[11:10]);
   endproperty
   a_rd_oc14_low: assert property (p_rd_oc14_low)
      else $error("0x6c low field does not match offset order2");

   property p_rd_oc14_spare;
      s_rd(`ATC_OFF_OC14) |=> bus_rdata[7:2] == `ATC_SPARE_VAL;
   endproperty
   a_rd_oc14_spare: assert property (p_rd_oc14_spare)
      else $error("0x6c spare field not zero");

   property p_rd_gc1;
      s_rd(`ATC_OFF_GC1)
      |=> bus_rdata == $past(st_q.coeff.gain_coeff_order0[7:0]);
   endproperty
   a_rd_gc1: assert property (p_rd_gc1)
      else $error("0x6d does not match gain order0");

   property p_rd_gc2_low;
      s_rd(`ATC_OFF_GC2)
      |=> bus_rdata[6:0] == $past(st_q.coeff.gain_coeff_order0[14:8]);
   endproperty
   a_rd_gc2_low: assert property (p_rd_gc2_low)
      else $error("0x6e low field does not match gain order0");

   property p_rd_gc2_high;
      s_rd(`ATC_OFF_GC2)
      |=> bus_rdata[7] == $past(st_q.coeff.gain_coeff_order1[0]);
   endproperty
   a_rd_gc2_high: assert property (p_rd_gc2_high)
      else $error("0x6e bit 7 does not match gain order1");

   property p_rd_gc3;
      s_rd(`ATC_OFF_GC3)
      |=> bus_rdata == $past(st_q.coeff.gain_coeff_order1[8:1]);
   endproperty
   a_rd_gc3: assert property (p_rd_gc3)
      else $error("0x6f does not match gain order1");

   property p_rd_gc4;
      s_rd(`ATC_OFF_GC4)
      |=> (bus_rdata[4:0] == $past(st_q.coeff.gain_coeff_order1[13:9]))
          && (bus_rdata[7:5] == $past(st_q.coeff.gain_coeff_order2[2:0]));
   endproperty
   a_rd_gc4: assert property (p_rd_gc4)
      else $error("0x70 does not match gain order1 and order2");

   property p_rd_gc5;
      s_rd(`ATC_OFF_GC5)
      |=> bus_rdata == $past(st_q.coeff.gain_coeff_order2[10:3]);
   endproperty
   a_rd_gc5: assert property (p_rd_gc5)
      else $error("0x71 does not match gain order2");

   property p_rd_oc11;
      s_rd(`ATC_OFF_OC11)
      |=> (bus_rdata[7:2] == $past(st_q.coeff.offset_coeff_order1[5:0]))
          && (bus_rdata[1:0] == `ATC_OC11_LOW);
   endproperty
   a_rd_oc11: assert property (p_rd_oc11)
      else $error("0x69 does not match offset order1");

   property p_reset_zero;
      @(posedge ref_clk) disable iff (1'b0)
      reset |=> (coeff_out == '0) && !bus_rvalid && !wr_ignored
                && (bus_rdata == `ATC_RST_BYTE);
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("coefficients not zero after reset");

   property p_hold_without_load;
      !trim_load [*2] |=> $stable(coeff_out);
   endproperty
   a_hold_without_load: assert property (p_hold_without_load)
      else $error("coefficients changed without a trim load");

   property p_write_ignored;
      bus_req.wr && !trim_load
      |=> (coeff_out == $past(coeff_out)) && !bus_rvalid;
   endproperty
   a_write_ignored: assert property (p_write_ignored)
      else $error("software write changed a coefficient");

   property p_write_flag;
      bus_req.wr && hit |=> wr_ignored ##1 !wr_ignored || $past(bus_req.wr);
   endproperty
   a_write_flag: assert property (p_write_flag)
      else $error("ignored write not flagged for one cycle");

   property p_unmapped_zero;
      bus_req.rd && !hit |=> bus_rvalid && (bus_rdata == `ATC_RST_BYTE);
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero)
      else $error("unmapped read did not return zero");

   property p_rdata_only_after_read;
      !bus_req.rd |=> !bus_rvalid && (bus_rdata == `ATC_RST_BYTE);
   endproperty
   a_rdata_only_after_read: assert property (p_rdata_only_after_read)
      else $error("read data present without a read");

   // Software view: each coefficient put back together from the byte image, so the
   // split across neighbouring bytes is checked as a whole and not only byte by byte
   atc_coeff_t rebuilt;

   always_comb
   begin
      rebuilt.offset_coeff_order1 = {bank[1][5:0], bank[0][7:2]};
      rebuilt.offset_coeff_order2 = {bank[3][1:0], bank[2], bank[1][7:6]};
      rebuilt.gain_coeff_order0   = {bank[5][6:0], bank[4]};
      rebuilt.gain_coeff_order1   = {bank[7][4:0], bank[6], bank[5][7]};
      rebuilt.gain_coeff_order2   = {bank[8], bank[7][7:5]};
   end

   property p_rebuild_off1;
      rebuilt.offset_coeff_order1 == st_q.coeff.offset_coeff_order1;
   endproperty
   a_rebuild_off1: assert property (p_rebuild_off1)
      else $error("offset order1 does not reassemble from 0x69 and 0x6a");

   property p_rebuild_off2;
      rebuilt.offset_coeff_order2 == st_q.coeff.offset_coeff_order2;
   endproperty
   a_rebuild_off2: assert property (p_rebuild_off2)
      else $error("offset order2 does not reassemble from 0x6a to 0x6c");

   property p_rebuild_gain0;
      rebuilt.gain_coeff_order0 == st_q.coeff.gain_coeff_order0;
   endproperty
   a_rebuild_gain0: assert property (p_rebuild_gain0)
      else $error("gain order0 does not reassemble from 0x6d and 0x6e");

   property p_rebuild_gain1;
      rebuilt.gain_coeff_order1 == st_q.coeff.gain_coeff_order1;
   endproperty
   a_rebuild_gain1: assert property (p_rebuild_gain1)
      else $error("gain order1 does not reassemble from 0x6e to 0x70");

   property p_rebuild_gain2;
      rebuilt.gain_coeff_order2 == st_q.coeff.gain_coeff_order2;
   endproperty
   a_rebuild_gain2: assert property (p_rebuild_gain2)
      else $error("gain order2 does not reassemble from 0x70 and 0x71");

   property p_rvalid_cause;
      bus_rvalid |-> $past(bus_req.rd);
   endproperty
   a_rvalid_cause: assert property (p_rvalid_cause)
      else $error("read valid without a read strobe one cycle before");

   property p_wr_ignored_cause;
      wr_ignored |-> $past(bus_req.wr && hit);
   endproperty
   a_wr_ignored_cause: assert property (p_wr_ignored_cause)
      else $error("write flag without a mapped write one cycle before");

   property p_unmapped_write_silent;
      bus_req.wr && !hit |=> !wr_ignored;
   endproperty
   a_unmapped_write_silent: assert property (p_unmapped_write_silent)
      else $error("unmapped write raised the write flag");

   property p_write_no_data;
      bus_req.wr |=> bus_rdata == `ATC_RST_BYTE;
   endproperty
   a_write_no_data: assert property (p_write_no_data)
      else $error("write produced read data");

   property p_load_lands;
      trim_load |=> coeff_out == $past(trim_coeff);
   endproperty
   a_load_lands: assert property (p_load_lands)
      else $error("trim load did not land on the next cycle");

   property p_coeff_change_cause;
      !$stable(coeff_out) |-> $past(trim_load) || $past(reset);
   endproperty
   a_coeff_change_cause: assert property (p_coeff_change_cause)
      else $error("coefficients changed with no load and no reset");

   property p_read_beside_load;
      trim_load && bus_req.rd && (bus_req.addr == `ATC_OFF_OC13)
      |=> bus_rdata == $past(st_q.coeff.offset_coeff_order2[9:2]);
   endproperty
   a_read_beside_load: assert property (p_read_beside_load)
      else $error("read beside a load did not return the old byte");

   property p_load_then_read;
      trim_load ##1 s_rd(`ATC_OFF_OC13)
      |=> bus_rdata == $past(trim_coeff.offset_coeff_order2[9:2], 2);
   endproperty
   a_load_then_read: assert property (p_load_then_read)
      else $error("read after a load did not return the new byte");

   property p_idx_in_range;
      hit |-> idx < `ATC_IDX_W'(`ATC_NUM_REGS);
   endproperty
   a_idx_in_range: assert property (p_idx_in_range)
      else $error("decode index beyond the last entry");

   // One read and one write check per mapped entry, so a decode slip on a single
   // address is caught wherever the two entries involved hold different bytes
   for (genvar gi = 0; gi < `ATC_NUM_REGS; gi++)
   begin : g_entry
      localparam logic [`ATC_ADDR_W-1:0] entry_addr = `ATC_ADDR_W'(`ATC_OFF_FIRST + gi);

      property p_entry_rd;
         @(posedge ref_clk) disable iff (reset)
         s_rd(entry_addr) |=> bus_rvalid && (bus_rdata == $past(bank[gi]));
      endproperty
      a_entry_rd: assert property (p_entry_rd)
         else $error("mapped read did not return its own entry");

      property p_entry_wr;
         @(posedge ref_clk) disable iff (reset)
         bus_req.wr && (bus_req.addr == entry_addr) && !trim_load
         |=> wr_ignored && $stable(bank[gi]);
      endproperty
      a_entry_wr: assert property (p_entry_wr)
         else $error("write to a mapped entry was not refused");
   end

   c_read_oc12: cover property (s_rd(`ATC_OFF_OC12) ##1 bus_rdata != 8'h00);
   c_load_then_read: cover property (trim_load ##1 s_rd(`ATC_OFF_OC13));
   c_read_beside_load: cover property (trim_load && bus_req.rd);
   c_write_ignored: cover property (bus_req.wr && hit ##1 wr_ignored);
   c_unmapped: cover property (bus_req.rd && !hit);
endmodule

// [atc_trim_bank_tb_top.sv]
// Self-checking bench for the coefficient trim bank
`timescale 1ns/10ps
module atc_trim_bank_tb_top
   import atc_pkg::*;
;
   logic         ref_clk;
   logic         reset;
   atc_bus_req_t bus_req;
   logic [7:0]   bus_rdata;
   logic         bus_rvalid;
   logic         wr_ignored;
   logic         trim_load;
   atc_coeff_t   trim_coeff;
   atc_coeff_t   coeff_out;
   int           n_mismatch;
   int           num_checks;
   atc_coeff_t   pat [3];

   atc_trim_bank i_dut
   (
      .ref_clk    (ref_clk),
      .reset      (reset),
      .bus_req    (bus_req),
      .bus_rdata  (bus_rdata),
      .bus_rvalid (bus_rvalid),
      .wr_ignored (wr_ignored),
      .trim_load  (trim_load),
      .trim_coeff (trim_coeff),
      .coeff_out  (coeff_out)
   );

   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   task automatic close_out();
      if (n_mismatch == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Byte image of the coefficients as software should see it
   function automatic logic [7:0] exp_byte(input atc_coeff_t c, input logic [7:0] a);
      case (a)
         8'h69:   return {c.offset_coeff_order1[5:0], 2'h0};
         8'h6a:   return {c.offset_coeff_order2[1:0], c.offset_coeff_order1[11:6]};
         8'h6b:   return c.offset_coeff_order2[9:2];
         8'h6c:   return {6'h00, c.offset_coeff_order2[11:10]};
         8'h6d:   return c.gain_coeff_order0[7:0];
         8'h6e:   return {c.gain_coeff_order1[0], c.gain_coeff_order0[14:8]};
         8'h6f:   return c.gain_coeff_order1[8:1];
         8'h70:   return {c.gain_coeff_order2[2:0], c.gain_coeff_order1[13:9]};
         8'h71:   return c.gain_coeff_order2[10:3];
         default: return 8'h00;
      endcase
   endfunction

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      bus_req <= '0;
      #1;
      chk(bus_rvalid, 1'b1);
      chk(bus_rdata, exp);
   endtask

   task automatic wr_chk(input logic [7:0] a, input logic exp_ign);
      @(posedge ref_clk);
      bus_req <= '{addr: a, wdata: 8'hff, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      bus_req <= '0;
      #1;
      chk(wr_ignored, exp_ign);
      chk(bus_rvalid, 1'b0);
   endtask

   task automatic load(input atc_coeff_t c);
      @(posedge ref_clk);
      trim_load  <= 1'b1;
      trim_coeff <= c;
      @(posedge ref_clk);
      trim_load  <= 1'b0;
      #1;
      chk(coeff_out, c);
   endtask

   task automatic read_all(input atc_coeff_t c);
      for (int i = 0; i < 9; i++)
         rd_chk(8'h69 + i[7:0], exp_byte(c, 8'h69 + i[7:0]));
   endtask

   // Hang guard: the whole run is far shorter than this
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      n_mismatch++;
      close_out();
   end

   initial
   begin
      n_mismatch = 0;
      num_checks = 0;
      reset      = 1'b1;
      bus_req    = '0;
      trim_load  = 1'b0;
      trim_coeff = '0;
      pat[0] = atc_coeff_t'(64'hffff_ffff_ffff_ffff);
      pat[1] = atc_coeff_t'(64'h5555_5555_5555_5555);
      pat[2] = atc_coeff_t'(64'h0123_4567_89ab_cdef);
      repeat (16) @(posedge ref_clk);
      reset <= 1'b0;
      #1;
      chk(coeff_out, '0);
      read_all('0);
      // The all-ones pattern and the zero readback before it exercise every field bit in both polarities
      foreach (pat[p])
      begin
         load(pat[p]);
         read_all(pat[p]);
      end
      // Writes with all ones must neither land nor disturb readback
      for (int i = 0; i < 9; i++)
         wr_chk(8'h69 + i[7:0], 1'b1);
      wr_chk(8'h72, 1'b0);
      chk(coeff_out, pat[2]);
      read_all(pat[2]);
      rd_chk(8'h68, 8'h00);
      rd_chk(8'h72, 8'h00);
      // Reset in mid-run must clear the loaded values
      load(pat[0]);
      // A read beside a load still sees the old byte; the next one sees the new
      @(posedge ref_clk);
      trim_load  <= 1'b1;
      trim_coeff <= pat[1];
      bus_req    <= '{addr: 8'h6b, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      trim_load <= 1'b0;
      #1;
      chk(bus_rdata, exp_byte(pat[0], 8'h6b));
      @(posedge ref_clk);
      bus_req <= '0;
      #1;
      chk(bus_rdata, exp_byte(pat[1], 8'h6b));
      @(posedge ref_clk);
      reset <= 1'b1;
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      #1;
      chk(coeff_out, '0);
      read_all('0);
      close_out();
   end
endmodule
